// ### hw/pts_pkg.sv
package pts_pkg;

  localparam int DATA_W = 8;
  localparam int REGS_PER_POT = 4;
  localparam int NUM_POTS_DEF = 2;

  // Bit count of the acknowledge slot (ninth clock of a byte)
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Device-type nibble; value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h9;

  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_DATA = 4'hB;
  localparam logic [3:0] OP_WR_DATA = 4'hC;

  localparam logic [DATA_W-1:0] SETTING_RESET = 8'h80;

  localparam int CLK_PERIOD_NS = 100;
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  // Longest time, so the count rounds down
  localparam int PROGRAM_CYCLES =
    PROGRAM_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_INSTR = 3'b011,
    ST_RX = 3'b010,
    ST_TX = 3'b110,
    ST_WAIT = 3'b111
  } pts_state_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
  } pts_instr_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sda_cap;
    logic wp_b;
    logic [3:0] addr;
  } pts_pins_t;

endpackage : pts_pkg

// ### hw/pts_nv_mem.sv
`timescale 1ns/1ns
module pts_nv_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Reset stands in for power-up of a fresh part
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge clk)
    begin
      if (!rst_b)
        mem[i] <= RESET_VAL;
      else if (wr_en && wr_addr == AW'(i))
        mem[i] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data <= RESET_VAL;
    else
      rd_data <= mem[rd_addr];
  end

endmodule : pts_nv_mem

// ### hw/pts_two_wire_slave.sv
`timescale 1ns/1ns
module pts_two_wire_slave #(
  parameter logic [3:0] DEV_TYPE = pts_pkg::DEV_TYPE_DEF,
  parameter int NUM_POTS = pts_pkg::NUM_POTS_DEF,
  parameter int PROG_CYCLES = pts_pkg::PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_0,
  input wire logic addr_select_pin_1,
  input wire logic addr_select_pin_2,
  input wire logic addr_select_pin_3,
  input wire logic wp_b,
  output logic [pts_pkg::DATA_W-1:0] wiper_setting_reg [NUM_POTS],
  output logic program_busy
);

  localparam int POT_W = (NUM_POTS > 1) ? $clog2(NUM_POTS) : 1;
  localparam int MEM_AW = POT_W + 2;
  localparam int MEM_DEPTH = NUM_POTS * pts_pkg::REGS_PER_POT;
  localparam int BOOT_W = POT_W + 1;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [BOOT_W-1:0] BOOT_LAST = BOOT_W'(2 * NUM_POTS - 1);

  pts_pkg::pts_state_t state;
  pts_pkg::pts_pins_t pin_raw;
  pts_pkg::pts_pins_t pin_s1;
  pts_pkg::pts_pins_t pin_s2;
  pts_pkg::pts_pins_t pin_d;
  pts_pkg::pts_instr_t instr;
  pts_pkg::pts_instr_t instr_in;

  logic sda_cap;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic rise_evt;
  logic rx_bit;
  logic [3:0] bit_cnt;
  logic [6:0] shift;
  logic [7:0] byte_in;
  logic byte_end;
  logic ack_end;
  logic ack_go;
  logic addr_match;
  logic pot_ok;
  logic wiper_wr;
  logic bus_off;
  logic booting;
  logic [BOOT_W-1:0] boot_cnt;
  logic [POT_W-1:0] boot_pot;
  logic pending;
  logic [7:0] pend_data;
  logic commit;
  logic [CNT_W-1:0] prog_cnt;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic [MEM_AW-1:0] rd_addr;
  logic [MEM_AW-1:0] wr_addr;
  logic [7:0] mem_rd;

  // Link side: the data bit is caught on the master's own clock edge
  always_ff @(posedge scl)
  begin
    sda_cap <= sda_in;
  end

  assign pin_raw = {scl, sda_in, sda_cap, wp_b, addr_select_pin_3,
                    addr_select_pin_2, addr_select_pin_1, addr_select_pin_0};

  // Idle bus reads high; pins settle before the first START anyway
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_d <= '1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  assign start_cond = pin_s2.scl && pin_d.scl && pin_d.sda && !pin_s2.sda;
  assign stop_cond = pin_s2.scl && pin_d.scl && !pin_d.sda && pin_s2.sda;
  assign scl_rise = pin_s2.scl && !pin_d.scl;
  assign scl_fall = !pin_s2.scl && pin_d.scl;

  // Captured bit is read a cycle after the edge so it has surely settled
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rise_evt <= 1'b0;
    else
      rise_evt <= scl_rise;
  end

  assign rx_bit = pin_s2.sda_cap;
  assign byte_in = {shift, rx_bit};
  assign instr_in = byte_in;
  assign byte_end = rise_evt && bit_cnt == pts_pkg::LAST_DATA_BIT;
  assign ack_end = rise_evt && bit_cnt == pts_pkg::ACK_SLOT;
  assign addr_match = byte_in[7:4] == DEV_TYPE
                      && byte_in[3:0] == pin_s2.addr;
  assign pot_ok = int'(instr.pot_sel) < NUM_POTS;
  assign bus_off = program_busy || booting;
  assign wiper_wr = byte_end && state == pts_pkg::ST_RX && pot_ok
                    && instr.opcode == pts_pkg::OP_WR_WIPER;
  assign commit = stop_cond && pending && pin_s2.wp_b;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state <= pts_pkg::ST_IDLE;
    else if (stop_cond)
      state <= pts_pkg::ST_IDLE;
    else if (start_cond)
      state <= bus_off ? pts_pkg::ST_IDLE : pts_pkg::ST_ADDR;
    else if (ack_end)
    begin
      case (state)
        pts_pkg::ST_ADDR:
          state <= ack_go ? pts_pkg::ST_INSTR : pts_pkg::ST_WAIT;
        pts_pkg::ST_INSTR:
        begin
          case (instr.opcode)
            pts_pkg::OP_RD_WIPER,
            pts_pkg::OP_RD_DATA:
              state <= pts_pkg::ST_TX;
            pts_pkg::OP_WR_WIPER,
            pts_pkg::OP_WR_DATA:
              state <= pts_pkg::ST_RX;
            default:
              state <= pts_pkg::ST_WAIT;
          endcase
        end
        pts_pkg::ST_TX:
          state <= rx_bit ? pts_pkg::ST_WAIT : pts_pkg::ST_TX;
        pts_pkg::ST_RX:
          state <= pts_pkg::ST_RX;
        default:
          state <= state;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b || start_cond || stop_cond)
      bit_cnt <= 4'h0;
    else if (rise_evt)
      bit_cnt <= (bit_cnt == pts_pkg::ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      shift <= 7'h00;
    else if (rise_evt && bit_cnt < pts_pkg::ACK_SLOT)
      shift <= byte_in[6:0];
  end

  // Decision to acknowledge is taken when the eighth bit lands
  always_ff @(posedge clk)
  begin
    if (!rst_b || start_cond || stop_cond)
      ack_go <= 1'b0;
    else if (byte_end)
    begin
      case (state)
        pts_pkg::ST_ADDR:
          ack_go <= addr_match;
        pts_pkg::ST_INSTR:
          ack_go <= 1'b1;
        pts_pkg::ST_RX:
          ack_go <= !(instr.opcode == pts_pkg::OP_WR_DATA
                      && !pin_s2.wp_b);
        default:
          ack_go <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      instr <= '0;
    else if (byte_end && state == pts_pkg::ST_INSTR)
      instr <= instr_in;
  end

  // A write only becomes real once its whole data byte is in
  always_ff @(posedge clk)
  begin
    if (!rst_b || start_cond || stop_cond)
      pending <= 1'b0;
    else if (byte_end && state == pts_pkg::ST_RX && pot_ok
             && instr.opcode == pts_pkg::OP_WR_DATA && pin_s2.wp_b)
      pending <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pend_data <= 8'h00;
    else if (byte_end && state == pts_pkg::ST_RX)
      pend_data <= byte_in;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      program_busy <= 1'b0;
      prog_cnt <= '0;
    end
    else if (commit)
    begin
      program_busy <= 1'b1;
      prog_cnt <= CNT_W'(PROG_CYCLES - 1);
    end
    else if (program_busy)
    begin
      if (prog_cnt == '0)
        program_busy <= 1'b0;
      else
        prog_cnt <= prog_cnt - 1'b1;
    end
  end

  // Power-up recall walks the pots, two cycles each for the read latency
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      booting <= 1'b1;
      boot_cnt <= '0;
    end
    else if (booting)
    begin
      if (boot_cnt == BOOT_LAST)
        booting <= 1'b0;
      boot_cnt <= boot_cnt + 1'b1;
    end
  end

  assign boot_pot = boot_cnt[BOOT_W-1:1];
  assign rd_addr = booting ? {boot_pot, 2'b00}
                           : {instr.pot_sel[POT_W-1:0], instr.reg_sel};
  assign wr_addr = {instr.pot_sel[POT_W-1:0], instr.reg_sel};

  pts_nv_mem #(
    .WIDTH(pts_pkg::DATA_W),
    .DEPTH(MEM_DEPTH),
    .AW(MEM_AW),
    .RESET_VAL(pts_pkg::SETTING_RESET)
  ) u_saved (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(commit),
    .wr_addr(wr_addr),
    .wr_data(pend_data),
    .rd_addr(rd_addr),
    .rd_data(mem_rd)
  );

  for (genvar p = 0; p < NUM_POTS; p++)
  begin : g_wiper
    always_ff @(posedge clk)
    begin
      if (!rst_b)
        wiper_setting_reg[p] <= pts_pkg::SETTING_RESET;
      else if (booting && boot_cnt[0] && int'(boot_pot) == p)
        wiper_setting_reg[p] <= mem_rd;
      else if (wiper_wr && int'(instr.pot_sel) == p)
        wiper_setting_reg[p] <= byte_in;
    end
  end

  always_comb
  begin
    next_tx_byte = 8'h00;
    if (!pot_ok)
      next_tx_byte = 8'h00;
    else if (instr.opcode == pts_pkg::OP_RD_WIPER)
      next_tx_byte = wiper_setting_reg[instr.pot_sel[POT_W-1:0]];
    else
      next_tx_byte = mem_rd;
  end

  // Same register is sent again after each master acknowledge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      tx_byte <= 8'h00;
    else if (ack_end)
      tx_byte <= next_tx_byte;
  end

  // Open drain: only ever pulls low, never touches the clock line
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // Data changes only after a falling clock, so it is stable while high
  always_ff @(posedge clk)
  begin
    if (!rst_b || start_cond || stop_cond || bus_off)
      sda_oe <= 1'b0;
    else if (scl_fall)
    begin
      case (state)
        pts_pkg::ST_TX:
          sda_oe <= bit_cnt < pts_pkg::ACK_SLOT
                    && !tx_byte[~bit_cnt[2:0]];
        pts_pkg::ST_ADDR,
        pts_pkg::ST_INSTR,
        pts_pkg::ST_RX:
          sda_oe <= bit_cnt == pts_pkg::ACK_SLOT && ack_go;
        default:
          sda_oe <= 1'b0;
      endcase
    end
  end

endmodule : pts_two_wire_slave

// ### test/pts_two_wire_slave_assertions.sv
`timescale 1ns/1ns
module pts_slave_chk #(
  parameter int NUM_POTS = pts_pkg::NUM_POTS_DEF,
  parameter int PROG_CYCLES = pts_pkg::PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [pts_pkg::DATA_W-1:0] wiper_setting_reg [NUM_POTS],
  input wire logic program_busy
);
  int busy_cnt;
  logic [7:0] stop_hist;
  logic seen_start;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk)
    if (!rst_b || !program_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  // Raw pins, so detection latency of a few cycles is allowed
  always_ff @(posedge clk)
    if (!rst_b)
      stop_hist <= 8'h00;
    else
      stop_hist <= {stop_hist[6:0], scl && $rose(sda_in)};
  always_ff @(posedge clk)
    if (!rst_b)
      seen_start <= 1'b0;
    else if (scl && $fell(sda_in))
      seen_start <= 1'b1;
  sequence after_fall;
    $past(scl, 6) && !$past(scl, 2);
  endsequence
  open_drain_a:
    assert property (sda_oe |-> !sda_out) else $error("line driven high");
  oe_steady_a:
    assert property ($changed(sda_oe) |-> !scl) else $error("oe moved");
  ack_timing_a:
    assert property ($rose(sda_oe) |-> after_fall) else $error("oe timing");
  quiet_idle_a:
    assert property (!seen_start |-> !sda_oe) else $error("drive early");
  busy_mute_a:
    assert property (program_busy |-> !sda_oe) else $error("busy drive");
  busy_len_a:
    assert property ($fell(program_busy) |-> busy_cnt == PROG_CYCLES)
    else $error("busy length");
  busy_cap_a:
    assert property (busy_cnt <= PROG_CYCLES) else $error("busy too long");
  busy_cause_a:
    assert property ($rose(program_busy) |-> stop_hist != 8'h00)
    else $error("busy without stop");
  reset_state_a:
    assert property ($rose(rst_b) |-> !sda_oe && !program_busy &&
      wiper_setting_reg[0] == pts_pkg::SETTING_RESET)
    else $error("reset state");
endmodule : pts_slave_chk
bind pts_two_wire_slave pts_slave_chk #(
  .NUM_POTS(NUM_POTS), .PROG_CYCLES(PROG_CYCLES)
) u_pts_slave_chk (
  .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .wiper_setting_reg(wiper_setting_reg), .program_busy(program_busy)
);

// ### test/pts_master.sv
`timescale 1ns/1ns
module pts_master (
  input wire logic lclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic tk(input int n);
    repeat (n) @(posedge lclk);
  endtask : tk
  // One tick after the fall, so data never moves with the clock
  task automatic bit_io(input logic b, output logic r);
    tk(1);
    sda_low = !b;
    tk(7);
    scl = 1'b1;
    tk(2);
    r = sda;
    tk(2);
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic slot,
    output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(slot, r);
  endtask : xfer
  // Also serves as a repeated start
  task automatic start();
    tk(1);
    sda_low = 1'b0;
    tk(4);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tk(1);
    sda_low = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(4);
    sda_low = 1'b0;
    tk(8);
  endtask : stop
endmodule : pts_master

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int PROG = 400;
  localparam logic [3:0] STRAP = 4'hA;
  localparam logic [7:0] ADDR = {pts_pkg::DEV_TYPE_DEF, STRAP};
  localparam logic [7:0] RV = pts_pkg::SETTING_RESET;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic scl, m_low, sda_out, sda_oe, program_busy, nak;
  logic [7:0] q;
  logic [pts_pkg::DATA_W-1:0] wiper [pts_pkg::NUM_POTS_DEF];
  int fail_count = 0;
  int cmp_count = 0;
  // Pull-up: high unless a party pulls low
  wire sda = !(m_low || (sda_oe && !sda_out));
  always #50 clk = !clk;
  always #80 lclk = !lclk;
  pts_two_wire_slave #(.PROG_CYCLES(PROG)) u_pts_two_wire_slave (
    .clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp_b(wp_b),
    .addr_select_pin_0(STRAP[0]), .addr_select_pin_1(STRAP[1]),
    .addr_select_pin_2(STRAP[2]), .addr_select_pin_3(STRAP[3]),
    .wiper_setting_reg(wiper), .program_busy(program_busy));
  pts_master u_pts_master (.lclk(lclk), .sda(sda), .scl(scl),
    .sda_low(m_low));
  task automatic check(input string what, input logic [7:0] seen, exp);
    cmp_count++;
    fail_count += int'(seen !== exp);
    if (seen !== exp)
      $display("FAIL %s expected %h seen %h", what, exp, seen);
  endtask : check
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] d);
    u_pts_master.xfer(d, 1'b1, q, nak);
  endtask : wr
  task automatic cmd(input logic [7:0] ins);
    u_pts_master.start();
    wr(ADDR);
    check("addr nak", nak, 1'b0);
    wr(ins);
    check("ins nak", nak, 1'b0);
  endtask : cmd
  task automatic t_wiper();
    cmd(8'hA1);
    wr(8'h3C);
    check("data nak", nak, 1'b0);
    u_pts_master.stop();
    check("wiper1", wiper[1], 8'h3C);
    check("wiper0", wiper[0], RV);
  endtask : t_wiper
  task automatic t_read();
    cmd(8'h91);
    u_pts_master.xfer(8'hFF, 1'b0, q, nak);
    check("read", q, 8'h3C);
    u_pts_master.xfer(8'hFF, 1'b1, q, nak);
    check("reread", q, 8'h3C);
    u_pts_master.tk(4);
    check("released", sda_oe, 1'b0);
    u_pts_master.stop();
  endtask : t_read
  task automatic t_miss();
    logic [7:0] bad [2] = '{ADDR ^ 8'h10, ADDR ^ 8'h01};
    foreach (bad[i])
    begin
      u_pts_master.start();
      wr(bad[i]);
      check("bad addr", nak, 1'b1);
      wr(8'hA0);
      check("ignored", nak, 1'b1);
      u_pts_master.stop();
    end
  endtask : t_miss
  task automatic t_prog();
    cmd(8'hC0);
    wr(8'h5A);
    check("data nak", nak, 1'b0);
    u_pts_master.stop();
    check("busy", program_busy, 1'b1);
    u_pts_master.start();
    wr(ADDR);
    check("poll", nak, 1'b1);
    u_pts_master.stop();
    for (int i = 0; i < PROG && program_busy; i++)
      @(negedge clk);
    check("done", program_busy, 1'b0);
    cmd(8'hB0);
    u_pts_master.xfer(8'hFF, 1'b1, q, nak);
    check("saved", q, 8'h5A);
    u_pts_master.stop();
  endtask : t_prog
  task automatic t_wp();
    @(negedge clk) wp_b = 1'b0;
    cmd(8'hC4);
    wr(8'h77);
    check("wp nak", nak, 1'b1);
    u_pts_master.stop();
    check("wp busy", program_busy, 1'b0);
    @(negedge clk) wp_b = 1'b1;
    cmd(8'hB4);
    u_pts_master.xfer(8'hFF, 1'b1, q, nak);
    check("wp kept", q, RV);
    u_pts_master.stop();
  endtask : t_wp
  // Half a data byte, then the write is cut by a restart or a stop
  task automatic t_abort();
    cmd(8'hA0);
    repeat (4) u_pts_master.bit_io(1'b0, nak);
    u_pts_master.start();
    wr(ADDR);
    check("restart", nak, 1'b0);
    u_pts_master.stop();
    check("untouched", wiper[0], RV);
    cmd(8'hC0);
    repeat (4) u_pts_master.bit_io(1'b0, nak);
    u_pts_master.stop();
    check("cut busy", program_busy, 1'b0);
  endtask : t_abort
  // Unknown opcode, and a pot number past the last pot
  task automatic t_odd();
    cmd(8'h20);
    wr(8'h55);
    check("odd op", nak, 1'b1);
    u_pts_master.stop();
    cmd(8'hA3);
    wr(8'h11);
    u_pts_master.stop();
    check("no pot", wiper[1], 8'h3C);
    cmd(8'h93);
    u_pts_master.xfer(8'hFF, 1'b1, q, nak);
    check("no pot rd", q, 8'h00);
    u_pts_master.stop();
  endtask : t_odd
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    check("wiper0", wiper[0], RV);
    t_wiper();
    t_read();
    t_miss();
    t_prog();
    t_wp();
    t_abort();
    t_odd();
    conclude();
  end
  // Tests take about 7600 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : testbench
